// ===== led_flash_pkg.sv
// shared constants and carriers for the flash led register set
package led_flash_pkg;

  // seven-bit bus address of the device
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h53;

  // register addresses
  localparam logic [7:0] OFF_MONITOR = 8'h80;
  localparam logic [7:0] OFF_TORCH = 8'hA0;
  localparam logic [7:0] OFF_FLASH = 8'hB0;
  localparam logic [7:0] OFF_TIMEOUT = 8'hC0;
  localparam logic [7:0] OFF_FLAGS = 8'hD0;

  // reset values; unused bits keep these levels on every read
  localparam logic [7:0] MONITOR_RESET = 8'hF8;
  localparam logic [7:0] TORCH_RESET = 8'hFA;
  localparam logic [7:0] FLASH_RESET = 8'hFD;
  localparam logic [7:0] TIMEOUT_RESET = 8'hEF;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // writable bits of each register
  localparam logic [7:0] MONITOR_MASK = 8'h07;
  localparam logic [7:0] TORCH_MASK = 8'h07;
  localparam logic [7:0] FLASH_MASK = 8'h0F;
  localparam logic [7:0] TIMEOUT_MASK = 8'h3F;

  // field positions
  localparam int MON_EN_BIT = 0;
  localparam int MON_THR_LSB = 1;
  localparam int LIMIT_BIT = 5;

  // flag bit positions
  localparam int FLAG_EXPIRED = 0;
  localparam int FLAG_OVERHEAT = 1;
  localparam int FLAG_LED_FAIL = 2;
  localparam int FLAG_SYNC_ONE = 3;
  localparam int FLAG_SYNC_TWO = 4;
  localparam int FLAG_THERMISTOR = 5;
  localparam int FLAG_SPARE = 6;
  localparam int FLAG_INPUT_LOW = 7;

  typedef struct packed {
    logic monitor_enable;
    logic [1:0] input_trip_threshold;
    logic [2:0] torch_code;
    logic [3:0] flash_code;
    logic [4:0] timeout_code;
    logic high_current_limit;
  } settings_t;

  typedef struct packed {
    logic flash_timeout_done;
    logic die_overheat;
    logic led_failure;
    logic pa_sync_input_one;
    logic pa_sync_input_two;
    logic sync_one_mode;
    logic sync_two_mode;
    logic thermistor_sense;
    logic thermistor_mode;
    logic input_below_threshold;
  } fault_inputs_t;

endpackage : led_flash_pkg

// ===== bus_line_watch.sv
// edge and start/stop detection on the two serial bus lines
`timescale 1ns/1ps
module bus_line_watch (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic scl, // serial clock level
  input wire logic sda, // serial data level
  output logic scl_rise, // one-cycle pulse
  output logic scl_fall, // one-cycle pulse
  output logic start_seen, // one-cycle pulse, start or repeated start
  output logic stop_seen, // one-cycle pulse
  output logic sda_level // registered data level
);
  logic scl_q;
  logic sda_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign scl_rise = !scl_q && scl;
  assign scl_fall = scl_q && !scl;
  // data may only move while scl is low, so a change under high scl frames
  assign start_seen = scl_q && scl && sda_q && !sda;
  assign stop_seen = scl_q && scl && !sda_q && sda;
  assign sda_level = sda_q;

endmodule : bus_line_watch

// ===== flag_latch.sv
// sticky flag bits, cleared by a read, with set winning over clear
`timescale 1ns/1ps
module flag_latch #(
  parameter int WIDTH = 8
) (
  input wire logic clock, // system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] set, // condition per bit, level or pulse
  input wire logic clear, // one-cycle pulse, the register was read
  output logic [WIDTH-1:0] flags // latched flags
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (rst) begin
          flags[i] <= 1'b0;
        end else if (set[i]) begin
          flags[i] <= 1'b1;
        end else if (clear) begin
          flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule : flag_latch

// ===== led_flash_regs.sv
// bus-reached setting and flag registers of the flash led driver
`timescale 1ns/1ps
// Contract
// - threshold bits 2:1 pick trip, default 00
// - bit 0 enables input comparator, default off
// - torch code bits 2:0, reset 010
// - flash code bits 3:0, reset 1101
// - timeout code bits 4:0, reset 01111
// - bit 5 selects current limit, reset 1
// - flag 0 set by flash timeout expiry
// - flag 7 only when monitor enabled, input low
// - flag 5 thermistor low, thermistor mode only
// - flags 4,3 on sync input change, mode only
// - flag 2 reports led open or short
// - flag 1 reports die overheat; bit 6 unused
// - write is address, register, data, each acked
// - irq pin pulled low on thermistor/input flags; code does so only with irq mode on and the second sync pin as output
module led_flash_regs
  import led_flash_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clock, // 250 MHz system clock
  input wire logic rst, // synchronous reset, active high
  input wire logic scl, // serial bus clock level
  input wire logic sda_in, // serial bus data level
  output logic sda_out, // data drive value, always low
  output logic sda_oe_n, // low while pulling data low
  input wire fault_inputs_t faults, // analog and sequencer events
  input wire logic irq_mode_enable, // interrupt output mode on
  input wire logic sync_two_is_gpio_output, // second sync pin is output
  output logic irq_out, // irq pin drive value, always low
  output logic irq_oe_n, // low while pulling irq pin low
  output settings_t settings, // current settings to the analog side
  output logic [7:0] flags // latched fault and event flags
);

  typedef enum logic [8:0] {
    ST_IDLE = 9'b0_0000_0001,
    ST_DEV = 9'b0_0000_0010,
    ST_ACK_DEV = 9'b0_0000_0100,
    ST_REG = 9'b0_0000_1000,
    ST_ACK_REG = 9'b0_0001_0000,
    ST_WR = 9'b0_0010_0000,
    ST_ACK_WR = 9'b0_0100_0000,
    ST_RD = 9'b0_1000_0000,
    ST_RD_ACK = 9'b1_0000_0000
  } bus_state_t;

  bus_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] pointer;
  logic is_read;
  logic master_nack;
  logic [7:0] monitor_reg;
  logic [7:0] torch_reg;
  logic [7:0] flash_reg;
  logic [7:0] timeout_reg;
  logic [7:0] rd_value;
  logic [7:0] flag_set;
  logic sync_one_q;
  logic sync_two_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_level;
  logic byte_done;
  logic wr_done;
  logic load_rd;
  logic flags_read;

  bus_line_watch u_watch (
    .clock(clock),
    .rst(rst),
    .scl(scl),
    .sda(sda_in),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .sda_level(sda_level)
  );

  assign byte_done = scl_fall && (bit_cnt == 4'h8);
  assign wr_done = (state == ST_WR) && byte_done;
  assign load_rd = scl_fall && (((state == ST_ACK_DEV) && is_read) ||
                   ((state == ST_RD_ACK) && !master_nack));
  assign flags_read = load_rd && (pointer == OFF_FLAGS);

  always_comb begin
    if (pointer == OFF_MONITOR) begin
      rd_value = monitor_reg;
    end else if (pointer == OFF_TORCH) begin
      rd_value = torch_reg;
    end else if (pointer == OFF_FLASH) begin
      rd_value = flash_reg;
    end else if (pointer == OFF_TIMEOUT) begin
      rd_value = timeout_reg;
    end else if (pointer == OFF_FLAGS) begin
      rd_value = flags;
    end else begin
      rd_value = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      is_read <= 1'b0;
      master_nack <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (stop_seen) begin
      state <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else if (start_seen) begin
      state <= ST_DEV;
      bit_cnt <= 4'h0;
      sda_oe_n <= 1'b1;
    end else begin
      case (state)
        ST_DEV, ST_REG, ST_WR: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_level};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            bit_cnt <= 4'h0;
            if (state == ST_REG) begin
              state <= ST_ACK_REG;
              sda_oe_n <= 1'b0;
            end else if (state == ST_WR) begin
              state <= ST_ACK_WR;
              sda_oe_n <= 1'b0;
            end else if (shift[7:1] == DEV_ADDR) begin
              state <= ST_ACK_DEV;
              is_read <= shift[0];
              sda_oe_n <= 1'b0;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ACK_DEV: begin
          if (scl_fall) begin
            if (is_read) begin
              state <= ST_RD;
              shift <= rd_value;
              sda_oe_n <= rd_value[7];
            end else begin
              state <= ST_REG;
              sda_oe_n <= 1'b1;
            end
          end
        end
        ST_ACK_REG: begin
          if (scl_fall) begin
            state <= ST_WR;
            sda_oe_n <= 1'b1;
          end
        end
        ST_ACK_WR: begin
          // one data byte per write; later bytes go unanswered
          if (scl_fall) begin
            state <= ST_IDLE;
            sda_oe_n <= 1'b1;
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_done) begin
            state <= ST_RD_ACK;
            bit_cnt <= 4'h0;
            sda_oe_n <= 1'b1;
          end else if (scl_fall) begin
            shift <= {shift[6:0], 1'b1};
            sda_oe_n <= shift[6];
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            master_nack <= sda_level;
          end else if (scl_fall) begin
            if (master_nack) begin
              state <= ST_IDLE;
            end else begin
              state <= ST_RD;
              shift <= rd_value;
              sda_oe_n <= rd_value[7];
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pointer <= 8'h00;
    end else if ((state == ST_REG) && byte_done) begin
      pointer <= shift;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      monitor_reg <= MONITOR_RESET;
      torch_reg <= TORCH_RESET;
      flash_reg <= FLASH_RESET;
      timeout_reg <= TIMEOUT_RESET;
    end else if (wr_done) begin
      if (pointer == OFF_MONITOR) begin
        monitor_reg <= (MONITOR_RESET & ~MONITOR_MASK) | (shift & MONITOR_MASK);
      end else if (pointer == OFF_TORCH) begin
        torch_reg <= (TORCH_RESET & ~TORCH_MASK) | (shift & TORCH_MASK);
      end else if (pointer == OFF_FLASH) begin
        flash_reg <= (FLASH_RESET & ~FLASH_MASK) | (shift & FLASH_MASK);
      end else if (pointer == OFF_TIMEOUT) begin
        timeout_reg <= (TIMEOUT_RESET & ~TIMEOUT_MASK) | (shift & TIMEOUT_MASK);
      end
    end
  end

  assign settings.monitor_enable = monitor_reg[MON_EN_BIT];
  assign settings.input_trip_threshold = monitor_reg[MON_THR_LSB +: 2];
  assign settings.torch_code = torch_reg[2:0];
  assign settings.flash_code = flash_reg[3:0];
  assign settings.timeout_code = timeout_reg[4:0];
  assign settings.high_current_limit = timeout_reg[LIMIT_BIT];

  always_ff @(posedge clock) begin
    if (rst) begin
      sync_one_q <= 1'b0;
      sync_two_q <= 1'b0;
    end else begin
      sync_one_q <= faults.pa_sync_input_one;
      sync_two_q <= faults.pa_sync_input_two;
    end
  end

  // conditions that persist keep their flag set through a read, since set wins over clear
  always_comb begin
    flag_set = 8'h00;
    flag_set[FLAG_EXPIRED] = faults.flash_timeout_done;
    flag_set[FLAG_OVERHEAT] = faults.die_overheat;
    flag_set[FLAG_LED_FAIL] = faults.led_failure;
    flag_set[FLAG_SYNC_ONE] = faults.sync_one_mode &&
      (sync_one_q != faults.pa_sync_input_one);
    flag_set[FLAG_SYNC_TWO] = faults.sync_two_mode &&
      (sync_two_q != faults.pa_sync_input_two);
    flag_set[FLAG_THERMISTOR] = faults.thermistor_mode &&
      faults.thermistor_sense;
    flag_set[FLAG_INPUT_LOW] = settings.monitor_enable &&
      faults.input_below_threshold;
  end

  flag_latch #(
    .WIDTH(8)
  ) u_flags (
    .clock(clock),
    .rst(rst),
    .set(flag_set),
    .clear(flags_read),
    .flags(flags)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_oe_n <= 1'b1;
      irq_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      irq_oe_n <= !(irq_mode_enable && sync_two_is_gpio_output &&
        (flags[FLAG_THERMISTOR] || flags[FLAG_INPUT_LOW]));
      irq_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  property p_mon_reset;
    @(posedge clock) disable iff (rst)
      $fell(rst) |-> !settings.monitor_enable;
  endproperty
  a_mon_reset: assert property (p_mon_reset)
    else $error("monitor enable not off after reset");

  property p_thr_write;
    @(posedge clock) disable iff (rst)
      (wr_done && pointer == OFF_MONITOR) |=>
        settings.input_trip_threshold == $past(shift[2:1]) &&
        settings.monitor_enable == $past(shift[0]);
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("monitor register write not applied");

  property p_torch_reset;
    @(posedge clock) disable iff (rst)
      $fell(rst) |-> settings.torch_code == 3'h2;
  endproperty
  a_torch_reset: assert property (p_torch_reset)
    else $error("torch code reset wrong");

  property p_flash_write;
    @(posedge clock) disable iff (rst)
      (wr_done && pointer == OFF_FLASH) |=>
        flash_reg == {4'hF, $past(shift[3:0])};
  endproperty
  a_flash_write: assert property (p_flash_write)
    else $error("flash register write wrong");

  property p_timeout_reset;
    @(posedge clock) disable iff (rst)
      $fell(rst) |-> settings.timeout_code == 5'h0F &&
        settings.high_current_limit;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset)
    else $error("timeout register reset wrong");

  property p_flag7;
    @(posedge clock) disable iff (rst)
      $rose(flags[FLAG_INPUT_LOW]) |->
        $past(settings.monitor_enable && faults.input_below_threshold);
  endproperty
  a_flag7: assert property (p_flag7)
    else $error("input flag set without enabled monitor");

  property p_flag0;
    @(posedge clock) disable iff (rst)
      faults.flash_timeout_done |=> flags[FLAG_EXPIRED] [*2];
  endproperty
  a_flag0: assert property (p_flag0)
    else $error("timeout flag lost");

  property p_flag_hold;
    @(posedge clock) disable iff (rst)
      (flags[FLAG_LED_FAIL] && !flags_read) |=> flags[FLAG_LED_FAIL];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without a read");

  property p_irq;
    @(posedge clock) disable iff (rst)
      (irq_mode_enable && sync_two_is_gpio_output &&
        flags[FLAG_THERMISTOR]) |=> !irq_oe_n;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq pin not pulled low");

  property p_ack;
    @(posedge clock) disable iff (rst)
      (state == ST_DEV && byte_done && shift[7:1] == DEV_ADDR) |=>
        !sda_oe_n && state == ST_ACK_DEV;
  endproperty
  a_ack: assert property (p_ack)
    else $error("address not acknowledged");

endmodule : led_flash_regs

// ===== led_flash_host.sv
// serial bus master model that reaches the setting and flag registers
`timescale 1ns/1ps
module led_flash_host
  import led_flash_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic sda_out, // device data drive value
  input wire logic sda_oe_n, // device pulls data low while low
  output logic scl, // serial clock
  output logic sda, // resolved data wire
  output logic res_v, // one-cycle pulse, read byte ready
  output logic [7:0] res_d, // byte read back
  output logic ack_v, // one-cycle pulse, write finished
  output logic ack_ok // every byte of the write was acked
);
  logic sda_m;
  int slow;
  // pulled up unless a party pulls low
  assign sda = (!sda_oe_n && !sda_out) ? 1'b0 : sda_m;
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
    slow = 2;
    res_v = 1'b0;
    res_d = 8'h00;
    ack_v = 1'b0;
    ack_ok = 1'b0;
  end
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  // data only moves while the clock is low
  task put_bit(input logic b, output logic r);
    sda_m <= b;
    cyc(slow);
    scl <= 1'b1;
    cyc(4);
    r = sda;
    scl <= 1'b0;
    cyc(slow);
  endtask : put_bit
  task start();
    sda_m <= 1'b1;
    cyc(2);
    scl <= 1'b1;
    cyc(4);
    sda_m <= 1'b0;
    cyc(4);
    scl <= 1'b0;
    cyc(2);
  endtask : start
  task stop();
    sda_m <= 1'b0;
    cyc(2);
    scl <= 1'b1;
    cyc(4);
    sda_m <= 1'b1;
    cyc(4);
  endtask : stop
  task send(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, nak);
  endtask : send
  task wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
    logic k0;
    logic k1;
    logic k2;
    start();
    send({dev, 1'b0}, k0);
    send(a, k1);
    send(d, k2);
    stop();
    ack_ok <= !(k0 | k1 | k2);
    ack_v <= 1'b1;
    cyc(1);
    ack_v <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    logic k;
    logic [7:0] v;
    start();
    send({DEV_ADDR_DEFAULT, 1'b0}, k);
    send(a, k);
    start();
    send({DEV_ADDR_DEFAULT, 1'b1}, k);
    for (int i = 7; i >= 0; i--) put_bit(1'b1, v[i]);
    put_bit(1'b1, k);
    stop();
    res_d <= v;
    res_v <= 1'b1;
    cyc(1);
    res_v <= 1'b0;
  endtask : rd
endmodule : led_flash_host

// ===== led_flash_regs_tb.sv
// self-checking bench for the flash led setting and flag registers
`timescale 1ns/1ps
module led_flash_regs_tb;
  import led_flash_pkg::*;
  logic clock;
  logic rst;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe_n;
  fault_inputs_t faults;
  logic irq_mode_enable;
  logic gpio_out;
  logic irq_out;
  logic irq_oe_n;
  settings_t settings;
  logic [7:0] flags;
  logic res_v;
  logic [7:0] res_d;
  logic ack_v;
  logic ack_ok;
  int err_total;
  int cmp_count;
  int cycles;
  logic [7:0] exp_byte[$];
  logic exp_ack[$];
  logic [7:0] offs[4] = '{OFF_MONITOR, OFF_TORCH, OFF_FLASH, OFF_TIMEOUT};
  logic [7:0] rsts[4] = '{MONITOR_RESET, TORCH_RESET, FLASH_RESET,
                          TIMEOUT_RESET};
  logic [7:0] masks[4] = '{MONITOR_MASK, TORCH_MASK, FLASH_MASK, TIMEOUT_MASK};
  logic [7:0] shadow[4];
  // cause pulse, steady mode levels and expected latched flags
  logic [9:0] pulse_tab[10] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h040,
                                10'h020, 10'h020, 10'h004, 10'h004, 10'h001};
  logic [9:0] base_tab[10] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h010,
                               10'h000, 10'h008, 10'h000, 10'h002, 10'h000};
  logic [7:0] flag_tab[10] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h08,
                               8'h00, 8'h10, 8'h00, 8'h20, 8'h00};

  led_flash_regs dut (
    .clock(clock),
    .rst(rst),
    .scl(scl),
    .sda_in(sda),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .faults(faults),
    .irq_mode_enable(irq_mode_enable),
    .sync_two_is_gpio_output(gpio_out),
    .irq_out(irq_out),
    .irq_oe_n(irq_oe_n),
    .settings(settings),
    .flags(flags)
  );
  led_flash_host host (
    .clock(clock),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .scl(scl),
    .sda(sda),
    .res_v(res_v),
    .res_d(res_d),
    .ack_v(ack_v),
    .ack_ok(ack_ok)
  );

  always #2 clock = ~clock;

  task cmp_v(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_v
  task cmp_ack(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t ack got %h exp %h", $time, got, exp);
    end
  endtask : cmp_ack
  task wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task wr_chk(input logic [7:0] a, input logic [7:0] d);
    exp_ack.push_back(1'b1);
    host.wr(DEV_ADDR_DEFAULT, a, d);
  endtask : wr_chk
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_byte.push_back(e);
    host.rd(a);
  endtask : rd_chk
  function automatic logic [15:0] exp_set();
    return {shadow[0][0], shadow[0][2:1], shadow[1][2:0], shadow[2][3:0],
            shadow[3][4:0], shadow[3][5]};
  endfunction : exp_set

  always @(posedge clock) begin
    if (res_v === 1'b1) begin
      cmp_v({8'h00, res_d}, {8'h00, exp_byte.pop_front()});
    end
    if (ack_v === 1'b1) begin
      cmp_ack(ack_ok, exp_ack.pop_front());
    end
    cycles++;
    // run is near 45k cycles; a hang stops here
    if (cycles == 90000) begin
      err_total++;
      wrap_up();
    end
  end

  initial begin
    logic [7:0] d;
    clock = 1'b0;
    rst = 1'b1;
    faults = '0;
    irq_mode_enable = 1'b0;
    gpio_out = 1'b0;
    err_total = 0;
    cmp_count = 0;
    cycles = 0;
    shadow = rsts;
    void'($urandom(11));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    cmp_v(settings, exp_set());
    for (int r = 0; r < 4; r++) rd_chk(offs[r], rsts[r]);
    rd_chk(OFF_FLAGS, FLAGS_RESET);
    // every field code, random unused bits, slow bus on one register
    for (int r = 0; r < 4; r++) begin
      host.slow = (r == 2) ? 5 : 2;
      for (int n = 0; n <= int'(masks[r]); n++) begin
        d = (8'($urandom()) & ~masks[r]) | 8'(n);
        shadow[r] = (d & masks[r]) | (rsts[r] & ~masks[r]);
        wr_chk(offs[r], d);
        cmp_v(settings, exp_set());
        if (n[1:0] == 2'b11) rd_chk(offs[r], shadow[r]);
      end
    end
    host.slow = 2;
    wr_chk(OFF_FLAGS, 8'hFF);
    rd_chk(OFF_FLAGS, 8'h00);
    wr_chk(8'h90, 8'h55);
    rd_chk(8'h90, 8'h00);
    exp_ack.push_back(1'b0);
    host.wr(DEV_ADDR_DEFAULT ^ 7'h01, OFF_TORCH, 8'h00);
    rd_chk(OFF_TORCH, shadow[1]);
    wr_chk(OFF_MONITOR, 8'h00);
    for (int i = 0; i < 10; i++) begin
      faults <= base_tab[i];
      repeat (3) @(posedge clock);
      faults <= base_tab[i] | pulse_tab[i];
      @(posedge clock);
      faults <= base_tab[i];
      repeat (3) @(posedge clock);
      cmp_v(flags, flag_tab[i]);
      rd_chk(OFF_FLAGS, flag_tab[i]);
      rd_chk(OFF_FLAGS, 8'h00);
    end
    faults <= 10'h001;
    wr_chk(OFF_MONITOR, 8'h01);
    irq_mode_enable <= 1'b1;
    gpio_out <= 1'b1;
    repeat (3) @(posedge clock);
    cmp_v(flags, 8'h80);
    cmp_v(irq_oe_n, 1'b0);
    cmp_v({irq_out, sda_out}, 2'b00);
    faults <= '0;
    rd_chk(OFF_FLAGS, 8'h80);
    cmp_v(irq_oe_n, 1'b1);
    gpio_out <= 1'b0;
    faults <= 10'h006;
    repeat (3) @(posedge clock);
    cmp_v(irq_oe_n, 1'b1);
    faults <= '0;
    rd_chk(OFF_FLAGS, 8'h20);
    @(posedge clock);
    wrap_up();
  end
endmodule : led_flash_regs_tb
